//--- hdl/timer2_pkg.sv
// Types shared by the reload/capture timer
package timer2_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef logic [1:0] evt_t;
endpackage

//--- hdl/timer2_regs.svh
// Register offsets, field positions, reset values and timing counts of the reload/capture timer
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// ************************************************************
// Register offsets (byte addresses on the register port)
// ************************************************************
`define OFS_PRIORITY_LOW 8'hb8
`define OFS_PRIORITY_HIGH 8'hb9
`define OFS_TIMER_CONTROL 8'hc8
`define OFS_RELOAD_CAPTURE_LOW 8'hca
`define OFS_RELOAD_CAPTURE_HIGH 8'hcb
`define OFS_COUNT_LOW 8'hcc
`define OFS_COUNT_HIGH 8'hcd
`define OFS_EVENT_STATUS 8'hce
`define OFS_EVENT_MASK 8'hcf

// ************************************************************
// Control register fields and the priority register bit position
// ************************************************************
`define BIT_OVERFLOW_FLAG 7
`define BIT_TRIGGER_EVENT_FLAG 6
`define BIT_RECEIVE_CLOCK_SOURCE 5
`define BIT_TRANSMIT_CLOCK_SOURCE 4
`define BIT_TRIGGER_ENABLE 3
`define BIT_RUN_BIT 2
`define BIT_COUNTER_TIMER_SELECT 1
`define BIT_CAPTURE_RELOAD_SELECT 0
`define BIT_PRIORITY 5

// ************************************************************
// Event status and mask fields
// ************************************************************
`define EVT_OVERFLOW 0
`define EVT_TRIGGER 1
`define EVT_WIDTH 2

// ************************************************************
// Reset values and timing
// ************************************************************
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_EVT 2'h0
`define TIMER_DIV_CYCLES 2

`endif

//--- hdl/timer2_reload_capture_unit.sv
// 16-bit timer/counter with auto-reload, capture and baud tick output
// Function
// - Overflow sets overflow flag unless a UART clock source bit is set; software clears.
// - Trigger-caused capture or reload sets trigger event flag; software clears.
// - Receive clock source bit picks timer1 or this overflow as receive clock.
// - Transmit clock source bit picks timer1 or this overflow as transmit clock.
// - Trigger falling edge acts only with enable set and both clock bits clear.
// - Counter advances only while the run bit is one.
// - Timer mode increments the count once every two clock cycles.
// - Counter mode increments the count on each count pin falling edge.
// - Reload mode reloads on overflow and on enabled trigger edges.
// - Capture mode captures on enabled trigger edges, no trigger reload.
// - Either clock source bit forces auto-reload on overflow, ignoring select bit.
// - Reload/capture value is readable and writable as two bytes, reset zero.
// - Running count is readable and writable as two bytes, reset zero.
// - Two-bit priority level from bit 5 of two registers, reset zero.
`timescale 1ns/100ps
`include "timer2_regs.svh"

module timer2_reload_capture_unit
  import timer2_pkg::*;
#(
  parameter int TIMER_DIV = `TIMER_DIV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic count_pin,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic priority_high_bit,
  output logic priority_low_bit,
  output logic irq
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Replace one byte of a 16-bit word
  function automatic word_t merge_byte(input word_t old, input byte_t b, input logic hi);
    merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  // Write strobe decode for one offset
  function automatic logic wr_at(input logic wr, input byte_t a, input byte_t ofs);
    wr_at = wr && (a == ofs);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  byte_t ctrl_q;
  word_t count_q;
  word_t rcap_q;
  evt_t status_q;
  evt_t mask_q;
  logic [3:0] presc_q;
  logic count_prev_q;
  logic trig_prev_q;
  logic prio_hi_q;
  logic prio_lo_q;
  byte_t rdata_q;
  logic rx_tick_q;
  logic tx_tick_q;
  logic irq_q;
  word_t count_d;
  word_t rcap_d;

  logic run, ct_sel, cr_sel, trig_en, rclk, transmit_clock_source, baud_mode;
  logic presc_tick, count_fall, trig_fall, inc_evt, ovf_evt, trig_act, reload_sel;
  logic wr_ctrl, wr_cl, wr_ch, wr_rl, wr_rh;

  assign run = ctrl_q[`BIT_RUN_BIT];
  assign ct_sel = ctrl_q[`BIT_COUNTER_TIMER_SELECT];
  assign cr_sel = ctrl_q[`BIT_CAPTURE_RELOAD_SELECT];
  assign trig_en = ctrl_q[`BIT_TRIGGER_ENABLE];
  assign rclk = ctrl_q[`BIT_RECEIVE_CLOCK_SOURCE];
  assign transmit_clock_source = ctrl_q[`BIT_TRANSMIT_CLOCK_SOURCE];
  assign baud_mode = rclk | transmit_clock_source;

  // Write decodes
  assign wr_ctrl = wr_at(reg_wr, reg_addr, `OFS_TIMER_CONTROL);
  assign wr_cl = wr_at(reg_wr, reg_addr, `OFS_COUNT_LOW);
  assign wr_ch = wr_at(reg_wr, reg_addr, `OFS_COUNT_HIGH);
  assign wr_rl = wr_at(reg_wr, reg_addr, `OFS_RELOAD_CAPTURE_LOW);
  assign wr_rh = wr_at(reg_wr, reg_addr, `OFS_RELOAD_CAPTURE_HIGH);

  // ************************************************************
  // Event detection
  // ************************************************************

  // Pins are synchronous, so one previous-value flop suffices for edges
  assign count_fall = count_prev_q & ~count_pin;
  assign trig_fall = trig_prev_q & ~trigger_pin;
  assign presc_tick = (presc_q == 4'(TIMER_DIV - 1));
  // Count source and gating
  assign inc_evt = run && (ct_sel ? count_fall : presc_tick);
  assign ovf_evt = inc_evt && (count_q == 16'hffff);
  // Trigger edges are dead while a baud clock is being produced
  assign trig_act = trig_fall && trig_en && !baud_mode;
  assign reload_sel = !cr_sel || baud_mode;

  // Edge history; idle-high reset so reset release is no edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_prev_q <= 1'b1;
      trig_prev_q <= 1'b1;
    end else begin
      count_prev_q <= count_pin;
      trig_prev_q <= trigger_pin;
    end
  end

  // Divide-by-two prescaler; held at zero while stopped or in counter mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= 4'h0;
    end else if (!run || ct_sel || presc_tick) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  // ************************************************************
  // Count and reload/capture value
  // ************************************************************

  // Software byte writes win over hardware in the same cycle
  always_comb begin
    count_d = count_q;
    if (inc_evt) begin
      if (!ovf_evt) begin
        count_d = count_q + 16'h0001;
      end else if (reload_sel) begin
        count_d = rcap_q;
      end else begin
        count_d = `RST_WORD;
      end
    end
    if (trig_act && !cr_sel) begin
      count_d = rcap_q;
    end
    if (wr_cl) begin
      count_d = merge_byte(count_d, reg_wdata, 1'b0);
    end
    if (wr_ch) begin
      count_d = merge_byte(count_d, reg_wdata, 1'b1);
    end
  end

  // Capture wins over a software write so a captured edge is kept
  always_comb begin
    rcap_d = rcap_q;
    if (wr_rl) begin
      rcap_d = merge_byte(rcap_d, reg_wdata, 1'b0);
    end
    if (wr_rh) begin
      rcap_d = merge_byte(rcap_d, reg_wdata, 1'b1);
    end
    if (trig_act && cr_sel) begin
      rcap_d = count_q;
    end
  end

  // Count and reload registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `RST_WORD;
      rcap_q <= `RST_WORD;
    end else begin
      count_q <= count_d;
      rcap_q <= rcap_d;
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (ovf_evt && !baud_mode) begin
        ctrl_q[`BIT_OVERFLOW_FLAG] <= 1'b1;
      end
      if (trig_act) begin
        ctrl_q[`BIT_TRIGGER_EVENT_FLAG] <= 1'b1;
      end
    end
  end

  // Priority level bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_hi_q <= 1'b0;
      prio_lo_q <= 1'b0;
    end else begin
      if (wr_at(reg_wr, reg_addr, `OFS_PRIORITY_HIGH)) begin
        prio_hi_q <= reg_wdata[`BIT_PRIORITY];
      end
      if (wr_at(reg_wr, reg_addr, `OFS_PRIORITY_LOW)) begin
        prio_lo_q <= reg_wdata[`BIT_PRIORITY];
      end
    end
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= `RST_EVT;
      mask_q <= `RST_EVT;
    end else begin
      status_q <= (status_q & ~(wr_at(reg_wr, reg_addr, `OFS_EVENT_STATUS) ?
                   reg_wdata[`EVT_WIDTH-1:0] : `RST_EVT)) |
                  {trig_act, ovf_evt && !baud_mode};
      if (wr_at(reg_wr, reg_addr, `OFS_EVENT_MASK)) begin
        mask_q <= reg_wdata[`EVT_WIDTH-1:0];
      end
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // ************************************************************
  // Baud tick outputs
  // ************************************************************

  // The UART decides itself whether it is in mode 1 or 3
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= rclk ? ovf_evt : timer1_overflow;
      tx_tick_q <= transmit_clock_source ? ovf_evt : timer1_overflow;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************

  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `RST_BYTE;
    end else if (!reg_rd) begin
      rdata_q <= `RST_BYTE;
    end else begin
      case (reg_addr)
        `OFS_TIMER_CONTROL: rdata_q <= ctrl_q;
        `OFS_RELOAD_CAPTURE_LOW: rdata_q <= rcap_q[7:0];
        `OFS_RELOAD_CAPTURE_HIGH: rdata_q <= rcap_q[15:8];
        `OFS_COUNT_LOW: rdata_q <= count_q[7:0];
        `OFS_COUNT_HIGH: rdata_q <= count_q[15:8];
        `OFS_PRIORITY_LOW: rdata_q <= {2'h0, prio_lo_q, 5'h00};
        `OFS_PRIORITY_HIGH: rdata_q <= {2'h0, prio_hi_q, 5'h00};
        `OFS_EVENT_STATUS: rdata_q <= {6'h00, status_q};
        `OFS_EVENT_MASK: rdata_q <= {6'h00, mask_q};
        default: rdata_q <= `RST_BYTE;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign rx_baud_tick = rx_tick_q;
  assign tx_baud_tick = tx_tick_q;
  assign priority_high_bit = prio_hi_q;
  assign priority_low_bit = prio_lo_q;
  assign irq = irq_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_ovf_flag;
    ovf_evt && !baud_mode |=> ctrl_q[`BIT_OVERFLOW_FLAG];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_no_flag_baud;
    ovf_evt && baud_mode && !wr_ctrl && !ctrl_q[`BIT_OVERFLOW_FLAG]
      |=> !ctrl_q[`BIT_OVERFLOW_FLAG];
  endproperty
  a_no_flag_baud: assert property (p_no_flag_baud) else $error("flag set in baud mode");

  property p_trig_flag;
    trig_act |=> ctrl_q[`BIT_TRIGGER_EVENT_FLAG] && status_q[`EVT_TRIGGER];
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger flag not set");

  property p_rx_tick;
    (rclk && ovf_evt) or (!rclk && timer1_overflow) |=> rx_baud_tick;
  endproperty
  a_rx_tick: assert property (p_rx_tick) else $error("receive tick missing");

  property p_tx_tick;
    (transmit_clock_source && ovf_evt) or (!transmit_clock_source && timer1_overflow) |=> tx_baud_tick;
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("transmit tick missing");

  // An overflow in the same cycle may still set its own flag, so it is left out
  property p_trig_ignored;
    trig_fall && (!trig_en || baud_mode) && !reg_wr && !ovf_evt
      |=> $stable(ctrl_q) && $stable(rcap_q);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

  property p_hold_stopped;
    !run && !trig_act && !wr_cl && !wr_ch |=> $stable(count_q);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

  sequence s_timer_quiet;
    run && !ct_sel && !reg_wr && !trig_act && count_q < 16'hfff0;
  endsequence
  property p_timer_rate;
    s_timer_quiet [*4] |-> count_q == $past(count_q, 3) + 16'h0001 ||
      count_q == $past(count_q, 3) + 16'h0002;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer rate wrong");

  property p_counter_edge;
    run && ct_sel && count_fall && !reg_wr && !trig_act && count_q != 16'hffff
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_counter_edge: assert property (p_counter_edge) else $error("counter edge missed");

  property p_reload_ovf;
    ovf_evt && reload_sel && !wr_cl && !wr_ch |=> count_q == $past(rcap_q);
  endproperty
  a_reload_ovf: assert property (p_reload_ovf) else $error("no reload on overflow");

  property p_reload_trig;
    trig_act && !cr_sel && !wr_cl && !wr_ch |=> count_q == $past(rcap_q);
  endproperty
  a_reload_trig: assert property (p_reload_trig) else $error("no reload on trigger");

  property p_capture;
    trig_act && cr_sel |=> rcap_q == $past(count_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_irq;
    |(status_q & mask_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

//--- tb/pin_source_model.sv
// Far-side model that drives the external count pin and trigger pin
`timescale 1ns/100ps

module pin_source_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cnt_req,
  input wire logic trg_req,
  output logic count_pin,
  output logic trigger_pin
);
  logic [1:0] cnt_low_q;
  logic [1:0] trg_low_q;

  // Pins idle high as if pulled up; a request pulls a pin low for two cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_low_q <= 2'h0;
      trg_low_q <= 2'h0;
    end else begin
      cnt_low_q <= {cnt_low_q[0], cnt_req};
      trg_low_q <= {trg_low_q[0], trg_req};
    end
  end

  // Two low cycles so the sampled falling edge is never missed
  assign count_pin = ~(|cnt_low_q);
  assign trigger_pin = ~(|trg_low_q);
endmodule

//--- tb/testbench.sv
// Self-checking bench for the reload/capture timer
`timescale 1ns/100ps
`include "timer2_regs.svh"

module testbench
  import timer2_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  byte_t reg_addr = 8'h00;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  byte_t reg_rdata;
  logic count_pin;
  logic trigger_pin;
  logic timer1_overflow = 1'b0;
  logic rx_baud_tick;
  logic tx_baud_tick;
  logic priority_high_bit;
  logic priority_low_bit;
  logic irq;
  logic cnt_req = 1'b0;
  logic trg_req = 1'b0;
  logic rd_seen = 1'b0;
  byte_t exp_q[$];
  byte_t adr_q[$];
  byte_t map_a[9] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hb8, 8'hb9, 8'hce, 8'hcf};
  int fail_count = 0;
  int cmp_count = 0;
  int rx_ticks = 0;
  int tx_ticks = 0;
  byte_t rnd = 8'h4a;
  byte_t rh;
  word_t cv;

  // ************************************************************
  // Clock, design and far side
  // ************************************************************
  always #2.5 clk = ~clk;

  timer2_reload_capture_unit #(.TIMER_DIV(2)) u_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin(count_pin),
    .trigger_pin(trigger_pin), .timer1_overflow(timer1_overflow),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .priority_high_bit(priority_high_bit), .priority_low_bit(priority_low_bit), .irq(irq)
  );

  pin_source_model u_pins (
    .clk(clk), .rst_b(rst_b), .cnt_req(cnt_req), .trg_req(trg_req),
    .count_pin(count_pin), .trigger_pin(trigger_pin)
  );

  // ************************************************************
  // Compare, verdict and bus tasks
  // ************************************************************
  function automatic byte_t lfsr(input byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_byte(input byte_t a, input byte_t e, input byte_t g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] reg_rdata at %h exp %h got %h", a, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic cmp_ticks(input int erx, input int etx);
    cmp_count++;
    if (rx_ticks != erx || tx_ticks != etx) begin
      fail_count++;
      $display("[ERR] baud ticks exp %0d/%0d got %0d/%0d", erx, etx, rx_ticks, tx_ticks);
    end
  endtask

  // One-cycle write; the next access leaves one idle cycle
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read notes the expected byte; the monitor compares it a cycle later
  task automatic rd(input byte_t a, input byte_t e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    adr_q.push_back(a);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wr16(input byte_t a, input word_t d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask

  task automatic rd16(input byte_t a, input word_t e);
    rd(a, e[7:0]);
    rd(a + 8'h01, e[15:8]);
  endtask

  // Falling edge on a pin from the far side, then let it settle
  task automatic pin_edge(input logic trg);
    @(posedge clk);
    if (trg) trg_req <= 1'b1;
    else cnt_req <= 1'b1;
    @(posedge clk);
    trg_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t1_pulse();
    @(posedge clk);
    timer1_overflow <= 1'b1;
    @(posedge clk);
    timer1_overflow <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Result watcher: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) cmp_byte(adr_q.pop_front(), exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
    if (rx_baud_tick === 1'b1) rx_ticks++;
    if (tx_baud_tick === 1'b1) tx_ticks++;
  end

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rd(map_a[i], `RST_BYTE);
    cmp_bit("priority_high_bit", 1'b0, priority_high_bit);
    wr(8'hc9, 8'hff);
    rd(8'hc9, 8'h00);
    wr(`OFS_PRIORITY_LOW, 8'hff);
    wr(`OFS_PRIORITY_HIGH, 8'h20);
    rd(`OFS_PRIORITY_LOW, 8'h20);
    cmp_bit("priority_low_bit", 1'b1, priority_low_bit);
    cmp_bit("priority_high_bit", 1'b1, priority_high_bit);
    rnd = lfsr(rnd);
    rh = rnd;
    rnd = lfsr(rnd);
    cv = {rnd, 8'h3c};
    wr16(`OFS_RELOAD_CAPTURE_LOW, {rh, rnd});
    rd16(`OFS_RELOAD_CAPTURE_LOW, {rh, rnd});
    // Timer rate: ten increments across twenty run cycles
    wr16(`OFS_COUNT_LOW, 16'h0000);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    repeat (18) @(posedge clk);
    wr(`OFS_TIMER_CONTROL, 8'h00);
    rd16(`OFS_COUNT_LOW, 16'h000a);
    // Overflow reloads, sets flag, status and interrupt
    wr16(`OFS_RELOAD_CAPTURE_LOW, {rh, 8'h00});
    wr16(`OFS_COUNT_LOW, 16'hffff);
    wr(`OFS_EVENT_MASK, 8'h01);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    repeat (4) @(posedge clk);
    rd(`OFS_TIMER_CONTROL, 8'h84);
    cmp_bit("irq", 1'b1, irq);
    wr(`OFS_TIMER_CONTROL, 8'h00);
    rd16(`OFS_COUNT_LOW, {rh, 8'h03});
    repeat (10) @(posedge clk);
    rd(`OFS_COUNT_LOW, 8'h03);
    rd(`OFS_EVENT_STATUS, 8'h01);
    wr(`OFS_EVENT_MASK, 8'h00);
    repeat (2) @(posedge clk);
    cmp_bit("irq", 1'b0, irq);
    wr(`OFS_EVENT_MASK, 8'h01);
    wr(`OFS_EVENT_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    cmp_bit("irq", 1'b0, irq);
    rd(`OFS_EVENT_STATUS, 8'h00);
    // Trigger ignored when disabled or when a clock source bit is set
    wr16(`OFS_COUNT_LOW, 16'h0000);
    pin_edge(1'b1);
    rd(`OFS_COUNT_HIGH, 8'h00);
    wr(`OFS_TIMER_CONTROL, 8'h18);
    pin_edge(1'b1);
    rd(`OFS_COUNT_HIGH, 8'h00);
    rd(`OFS_TIMER_CONTROL, 8'h18);
    wr(`OFS_TIMER_CONTROL, 8'h08);
    pin_edge(1'b1);
    rd(`OFS_COUNT_HIGH, rh);
    rd(`OFS_TIMER_CONTROL, 8'h48);
    rd(`OFS_EVENT_STATUS, 8'h02);
    // Capture copies the count out and leaves the count alone
    wr16(`OFS_COUNT_LOW, cv);
    wr(`OFS_TIMER_CONTROL, 8'h09);
    pin_edge(1'b1);
    rd16(`OFS_RELOAD_CAPTURE_LOW, cv);
    rd16(`OFS_COUNT_LOW, cv);
    wr16(`OFS_RELOAD_CAPTURE_LOW, {rh, 8'h00});
    // Capture mode overflow wraps to zero
    wr16(`OFS_COUNT_LOW, 16'hffff);
    wr(`OFS_TIMER_CONTROL, 8'h05);
    wr(`OFS_TIMER_CONTROL, 8'h01);
    rd16(`OFS_COUNT_LOW, 16'h0000);
    rd(`OFS_TIMER_CONTROL, 8'h81);
    // Clock source bit forces reload, no flag, tick on transmit side
    wr16(`OFS_COUNT_LOW, 16'hffff);
    wr(`OFS_TIMER_CONTROL, 8'h15);
    wr(`OFS_TIMER_CONTROL, 8'h11);
    rd(`OFS_COUNT_HIGH, rh);
    rd(`OFS_TIMER_CONTROL, 8'h11);
    cmp_ticks(0, 1);
    t1_pulse();
    cmp_ticks(1, 1);
    wr(`OFS_TIMER_CONTROL, 8'h00);
    t1_pulse();
    cmp_ticks(2, 2);
    wr(`OFS_TIMER_CONTROL, 8'h30);
    t1_pulse();
    cmp_ticks(2, 2);
    // Receive side fed by this overflow; no register write lands on the overflow cycle
    wr16(`OFS_COUNT_LOW, 16'hffff);
    wr(`OFS_TIMER_CONTROL, 8'h24);
    repeat (3) @(posedge clk);
    wr(`OFS_TIMER_CONTROL, 8'h20);
    rd16(`OFS_COUNT_LOW, {rh, 8'h01});
    rd(`OFS_TIMER_CONTROL, 8'h20);
    cmp_ticks(3, 2);
    // Counter mode follows count pin edges only
    wr16(`OFS_COUNT_LOW, 16'h0000);
    wr(`OFS_TIMER_CONTROL, 8'h06);
    for (int i = 0; i < 3; i++) pin_edge(1'b0);
    rd16(`OFS_COUNT_LOW, 16'h0003);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
